/* File: design/ddr_burst_pkg.sv */
package ddr_burst_pkg;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 4;
  localparam int BURST_LEN = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIRST_BEAT = 0;
  localparam int SECOND_BEAT = 1;
  localparam logic RST_OE = 1'b0;
  localparam logic RST_VALID = 1'b0;
  localparam logic RST_ECHO = 1'b0;
  localparam logic DIR_READ = 1'b1;
  typedef enum logic [1:0] {IDLE, BEAT0, BEAT1} beat_t;
endpackage : ddr_burst_pkg

/* File: design/ddr_burst_port.sv */
`timescale 1ns/1ns

// ----------------------------------------
// write burst queue
// ----------------------------------------
module burst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,             // clock
  input wire logic rst_n,                // async reset
  input wire logic inValid,              // push request
  output logic inReady,                  // room for one
  output logic nearFull,                 // at most one slot left
  input wire logic [WIDTH-1:0] inData,   // pushed word
  output logic outValid,                 // entry present
  input wire logic outReady,             // pop request
  output logic [WIDTH-1:0] outData       // head entry
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [PW:0] next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  assign outValid = (count != '0);
  assign outData = store[rdPtr];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
      nearFull <= 1'b0;
    end else begin
      if (push) wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= next_count;
      inReady <= (next_count != (PW+1)'(DEPTH));
      nearFull <= (next_count >= (PW+1)'(DEPTH - 1));
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) store[wrPtr] <= inData;
  end
endmodule : burst_fifo

// ----------------------------------------
// burst-of-two port
// ----------------------------------------
module ddr_burst_port
  import ddr_burst_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int LW = LANE_W,
  parameter int NL = LANES,
  parameter int AW = ADDR_W,
  parameter int QD = FIFO_DEPTH
) (
  input wire logic core_clk,                     // clock
  input wire logic rst_n,                        // async reset, low
  input wire logic load_strobe_n,                // transaction load, low
  input wire logic readWriteSel,                 // 1 read, 0 write
  input wire logic [AW-1:0] addr,                // burst address
  input wire logic [NL-1:0] byte_write_select_n, // lane enables, low
  input wire logic [DW-1:0] dqIn,                // bus level seen
  output logic [DW-1:0] dqOut,                   // bus drive value
  output logic dqOe,                             // bus drive enable
  output logic output_valid_flag,                // read data valid
  output logic echo_timing_output,               // echo clock
  output logic writeReady                        // write load may go
);
  localparam int EW = AW + 2 * DW + 2 * NL;
  localparam int MW = AW + 1;

  beat_t state;
  logic dir;
  logic [AW-1:0] burstAddr;
  logic [DW-1:0] firstWord;
  logic [NL-1:0] firstSel;
  logic [DW-1:0] mem [2**MW];

  logic fifoReady;
  logic fifoNear;
  logic qValid;
  logic [EW-1:0] qData;

  // ----------------------------------------
  // load and beat decode
  // ----------------------------------------
  wire canLoad = (state == IDLE) || (state == BEAT1);
  wire isRead = (readWriteSel == DIR_READ);
  wire writeBlocked = !fifoReady || (state == BEAT1 && !dir && fifoNear);
  wire loadAccept = canLoad && !load_strobe_n && (isRead || !writeBlocked);
  wire wrBeat0 = (state == BEAT0) && !dir;
  wire wrBeat1 = (state == BEAT1) && !dir;
  wire rdBeat0 = (state == BEAT0) && dir;
  wire readNext = (loadAccept && isRead) || rdBeat0;
  wire [MW-1:0] rdIdx = rdBeat0 ? {burstAddr, 1'(SECOND_BEAT)} : {addr, 1'(FIRST_BEAT)};
  wire [EW-1:0] pushData = {burstAddr, firstWord, firstSel, dqIn, byte_write_select_n};
  wire drain = qValid && !rdBeat0 && !(loadAccept && isRead);

  wire [AW-1:0] qAddr = qData[EW-1 -: AW];
  wire [DW-1:0] qWord0 = qData[2*NL+2*DW-1 -: DW];
  wire [NL-1:0] qSel0 = qData[2*NL+DW-1 -: NL];
  wire [DW-1:0] qWord1 = qData[NL+DW-1 -: DW];
  wire [NL-1:0] qSel1 = qData[NL-1:0];

  burst_fifo #(.WIDTH(EW), .DEPTH(QD)) u_queue (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(wrBeat1),
    .inReady(fifoReady),
    .nearFull(fifoNear),
    .inData(pushData),
    .outValid(qValid),
    .outReady(drain),
    .outData(qData)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      dir <= 1'b0;
      burstAddr <= '0;
    end else begin
      case (state)
        IDLE, BEAT1: state <= loadAccept ? BEAT0 : IDLE;
        BEAT0: state <= BEAT1;
        default: state <= IDLE;
      endcase
      if (loadAccept) begin
        dir <= isRead;
        burstAddr <= addr;
      end
    end
  end

  // first write word held until the second arrives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      firstWord <= '0;
      firstSel <= '1;
    end else if (wrBeat0) begin
      firstWord <= dqIn;
      firstSel <= byte_write_select_n;
    end
  end

  // ----------------------------------------
  // array, lane-masked drain
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (drain) begin
      for (int l = 0; l < NL; l++) begin
        if (!qSel0[l]) mem[{qAddr, 1'(FIRST_BEAT)}][l*LW +: LW] <= qWord0[l*LW +: LW];
        if (!qSel1[l]) mem[{qAddr, 1'(SECOND_BEAT)}][l*LW +: LW] <= qWord1[l*LW +: LW];
      end
    end
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqOut <= '0;
      dqOe <= RST_OE;
      output_valid_flag <= RST_VALID;
      echo_timing_output <= RST_ECHO;
      writeReady <= 1'b0;
    end else begin
      dqOut <= readNext ? mem[rdIdx] : '0;
      dqOe <= readNext;
      output_valid_flag <= readNext;
      echo_timing_output <= !echo_timing_output;
      writeReady <= fifoReady && !fifoNear;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_readLoad;
    loadAccept && isRead;
  endsequence
  sequence s_twoBeats;
    dqOe[*2];
  endsequence

  property p_read_two;
    @(posedge core_clk) disable iff (!rst_n) s_readLoad |=> s_twoBeats;
  endproperty
  a_read_two: assert property (p_read_two) else $error("read burst not two beats");

  property p_read_word0;
    @(posedge core_clk) disable iff (!rst_n) s_readLoad |=> dqOut == $past(mem[{addr, 1'(FIRST_BEAT)}]);
  endproperty
  a_read_word0: assert property (p_read_word0) else $error("first read word wrong");

  property p_release;
    @(posedge core_clk) disable iff (!rst_n) (!rdBeat0 && !(loadAccept && isRead)) |=> !dqOe && (dqOut == '0);
  endproperty
  a_release: assert property (p_release) else $error("bus driven while idle");

  property p_valid_oe;
    @(posedge core_clk) disable iff (!rst_n) output_valid_flag == dqOe;
  endproperty
  a_valid_oe: assert property (p_valid_oe) else $error("valid flag disagrees with drive");

  property p_no_start;
    @(posedge core_clk) disable iff (!rst_n) (load_strobe_n && state != BEAT0) |=> state == IDLE;
  endproperty
  a_no_start: assert property (p_no_start) else $error("burst started without load");

  property p_finish;
    @(posedge core_clk) disable iff (!rst_n) (state == BEAT0) |=> state == BEAT1;
  endproperty
  a_finish: assert property (p_finish) else $error("burst cut short");

  property p_addr_hold;
    @(posedge core_clk) disable iff (!rst_n) !loadAccept |=> $stable(burstAddr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed outside load");

  property p_dir;
    @(posedge core_clk) disable iff (!rst_n) loadAccept |=> dir == $past(readWriteSel);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not latched");

  property p_capture;
    @(posedge core_clk) disable iff (!rst_n) wrBeat0 |=> firstWord == $past(dqIn) ##1 !dqOe || dir;
  endproperty
  a_capture: assert property (p_capture) else $error("write word not captured");

  property p_push;
    @(posedge core_clk) disable iff (!rst_n) wrBeat1 |-> fifoReady;
  endproperty
  a_push: assert property (p_push) else $error("write burst pushed into full queue");
endmodule : ddr_burst_port

/* File: dv/ctrl_model.sv */
`timescale 1ns/1ns
// ---
// controller side of the port
// ---
module ctrl_model
  import ddr_burst_pkg::*;
(
  input wire logic core_clk, // clock
  output logic load_strobe_n, // load, low
  output logic readWriteSel, // direction
  output logic [ADDR_W-1:0] addr, // address
  output logic [LANES-1:0] byte_write_select_n, // lanes, low
  output logic [DATA_W-1:0] dqIn, // resolved bus
  input wire logic [DATA_W-1:0] dqOut, // device value
  input wire logic dqOe, // device enable
  input wire logic output_valid_flag // read valid
);
  logic drv;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] lastBus;
  initial begin
    {load_strobe_n, readWriteSel, addr, byte_write_select_n, drv, wd, lastBus} = '1;
    drv = 1'b0;
  end
  // floating bus shows the inverse of its last level
  assign dqIn = dqOe ? dqOut : (drv ? wd : ~lastBus);
  always @(posedge core_clk) lastBus <= dqIn;
  task automatic burst(input logic rw, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0, w1,
    input logic [LANES-1:0] s0, s1, input logic hold, output logic [DATA_W-1:0] r0, r1, output logic v);
    load_strobe_n = 1'b0;
    readWriteSel = rw;
    addr = a;
    @(negedge core_clk);
    load_strobe_n = ~hold;
    addr = ~a;
    drv = ~rw;
    wd = w0;
    byte_write_select_n = s0;
    r0 = dqIn;
    v = dqOe & output_valid_flag;
    @(negedge core_clk);
    if (hold) load_strobe_n = 1'b1;
    wd = w1;
    byte_write_select_n = s1;
    r1 = dqIn;
    v = v & dqOe & output_valid_flag;
  endtask : burst
  task automatic idle(input int n);
    @(negedge core_clk);
    drv = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask : idle
endmodule : ctrl_model

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb
  import ddr_burst_pkg::*;
;
  logic core_clk, rst_n, loadN, rw, dqOe, vld, writeReady, echo;
  logic [ADDR_W-1:0] a;
  logic [LANES-1:0] sel;
  logic [DATA_W-1:0] dqIn, dqOut, r0, r1;
  logic v;
  int n_errors = 0, compares = 0, cycles = 0;
  logic [15:0] seed = 16'h0043;
  logic [DATA_W-1:0] shadow [32];
  ddr_burst_port u_ddr_burst_port (.core_clk(core_clk), .rst_n(rst_n), .load_strobe_n(loadN),
    .readWriteSel(rw), .addr(a), .byte_write_select_n(sel), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .output_valid_flag(vld), .echo_timing_output(echo), .writeReady(writeReady));
  ctrl_model u_ctrl_model (.core_clk(core_clk), .load_strobe_n(loadN), .readWriteSel(rw), .addr(a),
    .byte_write_select_n(sel), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .output_valid_flag(vld));
  function automatic logic [DATA_W-1:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed[15:14], seed};
  endfunction : rnd
  // deselected lanes keep the old byte
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n, logic [LANES-1:0] s);
    for (int l = 0; l < LANES; l++) if (!s[l]) o[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
    return o;
  endfunction : merge
  task automatic chk_word(string name, logic [DATA_W-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", name, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(string name, logic exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic wr(logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] w0, w1, logic [LANES-1:0] s0, s1);
    for (int i = 0; i < 50 && writeReady !== 1'b1; i++) @(negedge core_clk);
    u_ctrl_model.burst(1'b0, ad, w0, w1, s0, s1, 1'b0, r0, r1, v);
    chk_bit("write valid", 1'b0, v);
    shadow[{ad, 1'b0}] = merge(shadow[{ad, 1'b0}], w0, s0);
    shadow[{ad, 1'b1}] = merge(shadow[{ad, 1'b1}], w1, s1);
  endtask : wr
  task automatic rd(logic [ADDR_W-1:0] ad, logic hold);
    u_ctrl_model.burst(1'b1, ad, '0, '0, '0, '0, hold, r0, r1, v);
    chk_word("word0", shadow[{ad, 1'b0}], r0);
    chk_word("word1", shadow[{ad, 1'b1}], r1);
    chk_bit("read valid", 1'b1, v);
  endtask : rd
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    logic [DATA_W-1:0] x, y, z;
    rst_n = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk_bit("echo first", 1'b1, echo);
    chk_bit("ready first", 1'b1, writeReady);
    chk_bit("oe first", 1'b0, dqOe);
    @(negedge core_clk);
    chk_bit("echo second", 1'b0, echo);
    // ---
    // fill, then partial-lane writes back to back
    // ---
    for (int i = 0; i < 16; i++) wr(ADDR_W'(i), rnd(), rnd(), 2'h0, 2'h0);
    wr(4'h5, rnd(), rnd(), 2'h3, 2'h3);
    for (int i = 0; i < 24; i++) begin
      x = rnd();
      y = rnd();
      z = rnd();
      wr(z[3:0], x, y, z[5:4], z[7:6]);
    end
    u_ctrl_model.idle(40);
    for (int i = 0; i < 16; i++) rd(ADDR_W'(i), 1'b0);
    u_ctrl_model.idle(0);
    chk_bit("oe idle", 1'b0, dqOe);
    rd(4'hA, 1'b1);
    u_ctrl_model.idle(0);
    chk_bit("oe held load", 1'b0, dqOe);
    // ---
    // reset in mid-run, then one write and read back
    // ---
    rst_n = 1'b0;
    #1;
    chk_bit("oe reset", RST_OE, dqOe);
    chk_bit("valid reset", RST_VALID, vld);
    chk_bit("echo reset", RST_ECHO, echo);
    chk_bit("ready reset", 1'b0, writeReady);
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk_bit("echo release", 1'b1, echo);
    chk_bit("oe release", 1'b0, dqOe);
    x = rnd();
    y = rnd();
    wr(4'h3, x, y, 2'h0, 2'h0);
    u_ctrl_model.idle(2);
    rd(4'h3, 1'b0);
    close_out();
  end
endmodule : tb
